// ---- hdl/etimer_cfg.svh ----
// offsets, field positions and timing constants of the elapsed timer
`ifndef ETIMER_CFG_SVH
`define ETIMER_CFG_SVH
`define CLK_HZ 25000000
`define TICK_CYC (`CLK_HZ / 1000)
`define DEBOUNCE_MS 50
`define DEBOUNCE_CYC (`DEBOUNCE_MS * `TICK_CYC)
`define RPT_DELAY_MS 10'd500
`define RPT_RATE_MS 10'd200
`define ALT_MS 10'd500
`define OFF_CTRL 8'h00
`define OFF_START 8'h04
`define OFF_STOP 8'h08
`define OFF_SECUR 8'h0c
`define OFF_TIMER 8'h10
`define OFF_STATUS 8'h14
`define OFF_CMD 8'h18
`define CTRL_RANGE 4:0
`define CTRL_MODE 7:5
`define CTRL_FILTER 8
`define CTRL_DIR 9
`define CTRL_STOPEN 10
`define CTRL_RUNIND 11
`define CTRL_PURESTORE 12
`define CTRL_PURESET 13
`define CTRL_SPSTOP 15:14
`define NUM_RANGES 5'd18
`define NUM_MODES 5'd7
`define LAST_SLOT 3'd5
`define LAST_ITEM 4'd9
`define LAST_DIGIT 3'd5
`define RST_RANGE 5'd0
`define RST_TIMER 24'h000000
`endif

// ---- hdl/etimer_pkg.sv ----
// types shared by the elapsed timer
package etimer_pkg;
  typedef enum logic [2:0] {
    level_run_mode, level_reset_mode, single_edge_mode, single_edge_reset_mode,
    dual_edge_mode, dual_edge_reset_mode, display_hold_mode
  } mode_t;
  typedef enum logic [1:0] {MENU_DISPLAY, MENU_PROMPT, MENU_EDIT} menu_t;
endpackage : etimer_pkg

// ---- hdl/etimer.sv ----
// elapsed timer with key programming menu and AHB-Lite register slave
`timescale 1ns/100ps
`include "etimer_cfg.svh"
module etimer #(
  parameter logic [14:0] TICK_CYCLES = 15'(`TICK_CYC),
  parameter logic [20:0] DEBOUNCE_CYCLES = 21'(`DEBOUNCE_CYC)
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic KEY_PAR,
  input wire logic KEY_SEL,
  input wire logic KEY_RST,
  input wire logic IN_A,
  input wire logic IN_B,
  input wire logic HW_LOCK,
  input wire logic SETPOINT,
  input wire logic NV_RUN,
  output logic [1:0] MENU_STATE,
  output logic [2:0] MENU_SLOT,
  output logic [3:0] MENU_ITEM,
  output logic SHOW_VALUE,
  output logic [23:0] EDIT_VALUE,
  output logic [2:0] FLASH_POS,
  output logic [23:0] TIMER_VALUE,
  output logic RUN_DP,
  output logic RUNNING,
  output logic LOCK_CODE,
  output logic LOCK_HW,
  output logic NV_WRITE
);
  // ****************************************
  // parameters and their lookups
  // ****************************************
  logic [4:0] range_r;
  etimer_pkg::mode_t mode_r;
  logic filter_r, dir_r, stop_en_r, run_ind_r, pu_restore_r, pu_reset_r;
  logic [1:0] spstop_r;
  logic [23:0] start_r, stop_r;
  logic [9:0] secur_r;

  function automatic logic [21:0] res_ms(input logic [4:0] rg);
    case (rg)
      5'd1, 5'd11: res_ms = 22'd100;
      5'd2, 5'd12: res_ms = 22'd10;
      5'd3: res_ms = 22'd1;
      5'd4, 5'd13, 5'd17: res_ms = 22'd60000;
      5'd5, 5'd14: res_ms = 22'd6000;
      5'd6, 5'd15: res_ms = 22'd600;
      5'd7: res_ms = 22'd3600000;
      5'd8: res_ms = 22'd360000;
      5'd9: res_ms = 22'd36000;
      default: res_ms = 22'd1000;
    endcase
  endfunction : res_ms

  // in ranges 10 to 17, digits holding tens of seconds or minutes stop at 5
  function automatic logic [5:0] six_mask(input logic [4:0] rg);
    case (rg)
      5'd10, 5'd13, 5'd17: six_mask = 6'h02;
      5'd11, 5'd14: six_mask = 6'h04;
      5'd12, 5'd15: six_mask = 6'h08;
      5'd16: six_mask = 6'h0a;
      default: six_mask = 6'h00;
    endcase
  endfunction : six_mask

  function automatic logic [23:0] bcd_step(input logic [23:0] v, input logic dn,
                                           input logic [4:0] rg);
    logic [23:0] r;
    logic c;
    logic [3:0] d, mx;
    logic [5:0] sm;
    r = v;
    c = 1'b1;
    sm = six_mask(rg);
    for (int i = 0; i < 6; i++) begin
      d = v[4*i +: 4];
      mx = sm[i] ? 4'h5 : 4'h9;
      if (c && !dn) begin
        c = (d >= mx);
        r[4*i +: 4] = c ? 4'h0 : d + 4'h1;
      end else if (c) begin
        c = (d == 4'h0);
        r[4*i +: 4] = c ? mx : d - 4'h1;
      end
    end
    if (rg == 5'd17 && r[15:8] == 8'h99) r[15:8] = 8'h23;
    if (rg == 5'd17 && r[15:8] == 8'h24) begin
      r[15:8] = 8'h00;
      r[19:16] = (r[19:16] == 4'h9) ? 4'h0 : r[19:16] + 4'h1;
      if (r[19:16] == 4'h0) r[23:20] = (r[23:20] == 4'h9) ? 4'h0 : r[23:20] + 4'h1;
    end
    return r;
  endfunction : bcd_step

  // ****************************************
  // pin synchronisers, key edges, debounce
  // ****************************************
  logic [5:0] s1_r, s2_r;
  logic [2:0] kprev_r;
  logic [1:0] flt, fprev_r;
  logic [2:0] press;
  logic par_p, sel_p, rst_p, rst_evt, a, b, a_rise, b_rise;
  always_ff @(posedge CLK) begin
    s1_r <= {HW_LOCK, KEY_RST, KEY_SEL, KEY_PAR, IN_B, IN_A};
    s2_r <= s1_r;
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      kprev_r <= 3'h7;
      fprev_r <= 2'h0;
    end else begin
      kprev_r <= s2_r[4:2];
      fprev_r <= flt;
    end
  end
  assign press = s2_r[4:2] & ~kprev_r;
  assign par_p = press[0];
  assign sel_p = press[1];
  assign rst_p = press[2];
  for (genvar i = 0; i < 2; i++) begin : g_flt
    logic [20:0] cnt_r;
    logic lvl_r;
    always_ff @(posedge CLK) begin
      if (RST) begin
        cnt_r <= 21'h0;
        lvl_r <= 1'b0;
      end else if (!filter_r || s2_r[i] == lvl_r) begin
        cnt_r <= 21'h0;
        lvl_r <= s2_r[i];
      end else if (cnt_r == DEBOUNCE_CYCLES - 21'h1) begin
        cnt_r <= 21'h0;
        lvl_r <= s2_r[i];
      end else begin
        cnt_r <= cnt_r + 21'h1;
      end
    end
    assign flt[i] = lvl_r;
  end
  assign a = flt[0];
  assign b = flt[1];
  assign a_rise = a & ~fprev_r[0];
  assign b_rise = b & ~fprev_r[1];

  // ****************************************
  // millisecond tick, key repeat, alternation
  // ****************************************
  logic [14:0] pre_r;
  logic ms_tick, alt_r;
  logic [9:0] rpt_r, alt_ms_r;
  assign ms_tick = (pre_r == TICK_CYCLES - 15'h1);
  always_ff @(posedge CLK) begin
    if (RST) pre_r <= 15'h0;
    else pre_r <= ms_tick ? 15'h0 : pre_r + 15'h1;
  end
  // repeat paced in milliseconds so no long counter is needed
  always_ff @(posedge CLK) begin
    if (RST || !s2_r[4]) rpt_r <= 10'h0;
    else if (ms_tick) rpt_r <= (rpt_r == `RPT_DELAY_MS - 10'h1) ?
                               `RPT_DELAY_MS - `RPT_RATE_MS : rpt_r + 10'h1;
  end
  assign rst_evt = rst_p | (s2_r[4] & ms_tick & (rpt_r == `RPT_DELAY_MS - 10'h1));
  always_ff @(posedge CLK) begin
    if (RST) begin
      alt_ms_r <= 10'h0;
      alt_r <= 1'b0;
    end else if (ms_tick) begin
      alt_ms_r <= (alt_ms_r == `ALT_MS - 10'h1) ? 10'h0 : alt_ms_r + 10'h1;
      if (alt_ms_r == `ALT_MS - 10'h1) alt_r <= ~alt_r;
    end
  end

  // ****************************************
  // AHB-Lite slave, zero wait states
  // ****************************************
  logic wr_pend_r, bus_wr;
  logic [7:0] wa_r;
  logic [31:0] hrdata_r, rd_word;
  logic [23:0] timer_r, disp_r;
  logic run_r, stop_lat_r, timing, lock_code_r, lock_hw_r, nv_wr_r;
  etimer_pkg::menu_t state_r;
  always_ff @(posedge CLK) begin
    if (RST) begin
      wr_pend_r <= 1'b0;
      wa_r <= 8'h0;
      hrdata_r <= 32'h0;
    end else begin
      wr_pend_r <= HSEL & HTRANS[1] & HREADY & HWRITE;
      wa_r <= HADDR[7:0];
      if (HSEL & HTRANS[1] & HREADY & ~HWRITE) hrdata_r <= rd_word;
    end
  end
  always_comb begin
    case (HADDR[7:0])
      `OFF_CTRL: rd_word = {16'h0, spstop_r, pu_reset_r, pu_restore_r, run_ind_r,
                            stop_en_r, dir_r, filter_r, mode_r, range_r};
      `OFF_START: rd_word = {8'h0, start_r};
      `OFF_STOP: rd_word = {8'h0, stop_r};
      `OFF_SECUR: rd_word = {22'h0, secur_r};
      `OFF_TIMER: rd_word = {8'h0, timer_r};
      `OFF_STATUS: rd_word = {25'h0, state_r, lock_hw_r, lock_code_r, stop_lat_r,
                              timing, run_r};
      default: rd_word = 32'h0;
    endcase
  end
  assign bus_wr = wr_pend_r;
  assign HRDATA = hrdata_r;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // ****************************************
  // programming menu
  // ****************************************
  logic [2:0] mod_r, pos_r;
  logic [3:0] item_r, next_item;
  logic [23:0] edit_r;
  logic [4:0] nch;
  logic numeric, store, locked;
  function automatic logic [23:0] cur_val(input logic [3:0] it);
    case (it)
      4'd0: cur_val = {19'h0, range_r};
      4'd1: cur_val = {21'h0, mode_r};
      4'd2: cur_val = {23'h0, filter_r};
      4'd3: cur_val = {23'h0, dir_r};
      4'd4: cur_val = start_r;
      4'd5: cur_val = {23'h0, stop_en_r};
      4'd6: cur_val = stop_r;
      4'd7: cur_val = {23'h0, run_ind_r};
      4'd8: cur_val = {23'h0, pu_restore_r};
      default: cur_val = {23'h0, pu_reset_r};
    endcase
  endfunction : cur_val
  assign numeric = (item_r == 4'd4) || (item_r == 4'd6);
  assign nch = (item_r == 4'd0) ? `NUM_RANGES : (item_r == 4'd1) ? `NUM_MODES : 5'd2;
  assign locked = (secur_r != 10'h0) | s2_r[5];
  assign store = (state_r == etimer_pkg::MENU_EDIT) & par_p;
  // stop value is offered only when its enable was just set
  assign next_item = (item_r == 4'd5 && !edit_r[0]) ? 4'd7 : item_r + 4'd1;
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_r <= etimer_pkg::MENU_DISPLAY;
      mod_r <= 3'h0;
      item_r <= 4'h0;
      pos_r <= 3'h0;
      edit_r <= 24'h0;
      lock_code_r <= 1'b0;
      lock_hw_r <= 1'b0;
      nv_wr_r <= 1'b0;
    end else begin
      nv_wr_r <= 1'b0;
      case (state_r)
        etimer_pkg::MENU_DISPLAY: begin
          if (par_p) begin
            lock_code_r <= (secur_r != 10'h0);
            lock_hw_r <= s2_r[5];
            mod_r <= 3'h0;
            if (!locked) state_r <= etimer_pkg::MENU_PROMPT;
          end
        end
        etimer_pkg::MENU_PROMPT: begin
          if (par_p && mod_r == 3'h0) begin
            state_r <= etimer_pkg::MENU_DISPLAY;
            nv_wr_r <= 1'b1;
          end else if (par_p && mod_r == 3'h1) begin
            state_r <= etimer_pkg::MENU_EDIT;
            item_r <= 4'h0;
            pos_r <= 3'h0;
            edit_r <= cur_val(4'h0);
          end else if (par_p) begin
            mod_r <= 3'h0;
          end else if (sel_p) begin
            mod_r <= (mod_r == `LAST_SLOT) ? 3'h0 : mod_r + 3'h1;
          end
        end
        etimer_pkg::MENU_EDIT: begin
          if (par_p && item_r == `LAST_ITEM) begin
            state_r <= etimer_pkg::MENU_PROMPT;
            mod_r <= 3'h0;
          end else if (par_p) begin
            item_r <= next_item;
            edit_r <= cur_val(next_item);
            pos_r <= 3'h0;
          end else if (sel_p && numeric) begin
            pos_r <= (pos_r == `LAST_DIGIT) ? 3'h0 : pos_r + 3'h1;
          end else if (sel_p) begin
            edit_r <= {19'h0, (edit_r[4:0] >= nch - 5'h1) ? 5'h0 : edit_r[4:0] + 5'h1};
          end else if (rst_evt && numeric) begin
            edit_r[{pos_r, 2'b00} +: 4] <= (edit_r[{pos_r, 2'b00} +: 4] >= 4'h9) ?
                                           4'h0 : edit_r[{pos_r, 2'b00} +: 4] + 4'h1;
          end else if (rst_evt) begin
            edit_r <= {19'h0, (edit_r[4:0] == 5'h0) ? nch - 5'h1 : edit_r[4:0] - 5'h1};
          end
        end
        default: state_r <= etimer_pkg::MENU_DISPLAY;
      endcase
    end
  end

  // ****************************************
  // parameter store: bus writes win over keys
  // ****************************************
  always_ff @(posedge CLK) begin
    if (RST) begin
      range_r <= `RST_RANGE;
      mode_r <= etimer_pkg::level_run_mode;
      {filter_r, dir_r, stop_en_r, run_ind_r, pu_restore_r, pu_reset_r} <= 6'h0;
      spstop_r <= 2'h0;
      start_r <= `RST_TIMER;
      stop_r <= `RST_TIMER;
      secur_r <= 10'h0;
    end else if (bus_wr) begin
      case (wa_r)
        `OFF_CTRL: begin
          range_r <= (HWDATA[`CTRL_RANGE] < `NUM_RANGES) ? HWDATA[`CTRL_RANGE] : range_r;
          mode_r <= etimer_pkg::mode_t'(HWDATA[`CTRL_MODE]);
          filter_r <= HWDATA[`CTRL_FILTER];
          dir_r <= HWDATA[`CTRL_DIR];
          stop_en_r <= HWDATA[`CTRL_STOPEN];
          run_ind_r <= HWDATA[`CTRL_RUNIND];
          pu_restore_r <= HWDATA[`CTRL_PURESTORE];
          pu_reset_r <= HWDATA[`CTRL_PURESET];
          spstop_r <= HWDATA[`CTRL_SPSTOP];
        end
        `OFF_START: start_r <= HWDATA[23:0];
        `OFF_STOP: stop_r <= HWDATA[23:0];
        `OFF_SECUR: secur_r <= HWDATA[9:0];
        default: ;
      endcase
    end else if (store) begin
      case (item_r)
        4'd0: range_r <= edit_r[4:0];
        4'd1: mode_r <= etimer_pkg::mode_t'(edit_r[2:0]);
        4'd2: filter_r <= edit_r[0];
        4'd3: dir_r <= edit_r[0];
        4'd4: start_r <= edit_r;
        4'd5: stop_en_r <= edit_r[0];
        4'd6: stop_r <= edit_r;
        4'd7: run_ind_r <= edit_r[0];
        4'd8: pu_restore_r <= edit_r[0];
        default: pu_reset_r <= edit_r[0];
      endcase
    end
  end

  // ****************************************
  // run/stop control and timing
  // ****************************************
  logic single, rvar, level, start_e, stop_e, tmr_rst, stop_set, sp_prev_r, pu_pend_r;
  logic [21:0] res_r;
  always_comb begin
    single = 1'b0;
    rvar = 1'b0;
    level = 1'b0;
    start_e = a_rise;
    stop_e = b_rise;
    case (mode_r)
      etimer_pkg::level_run_mode: {single, level, stop_e} = 3'b110;
      etimer_pkg::level_reset_mode: {single, level, rvar, stop_e} = 4'b1110;
      etimer_pkg::single_edge_mode, etimer_pkg::single_edge_reset_mode: begin
        single = 1'b1;
        rvar = (mode_r == etimer_pkg::single_edge_reset_mode);
        start_e = a_rise & ~run_r;
        stop_e = a_rise & run_r;
      end
      etimer_pkg::dual_edge_reset_mode: rvar = 1'b1;
      default: ;
    endcase
  end
  assign timing = run_r & ~stop_lat_r & ~(single & b);
  assign tmr_rst = (rst_p & (state_r == etimer_pkg::MENU_DISPLAY)) |
                   (bus_wr & (wa_r == `OFF_CMD) & HWDATA[0]) |
                   (rvar & start_e) | (pu_pend_r & pu_reset_r);
  assign stop_set = (stop_en_r & timing & (timer_r == stop_r)) |
                    (spstop_r == 2'h1 & SETPOINT & ~sp_prev_r) |
                    (spstop_r == 2'h2 & ~SETPOINT & sp_prev_r);
  always_ff @(posedge CLK) begin
    pu_pend_r <= RST;
    if (RST) run_r <= 1'b0;
    else if (level) run_r <= a;
    else if (pu_pend_r) run_r <= pu_restore_r & NV_RUN;
    else if (start_e) run_r <= 1'b1;
    else if (stop_e) run_r <= 1'b0;
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      stop_lat_r <= 1'b0;
      sp_prev_r <= 1'b0;
    end else begin
      sp_prev_r <= SETPOINT;
      if (stop_set) stop_lat_r <= 1'b1;
      else if (tmr_rst || start_e) stop_lat_r <= 1'b0;
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      timer_r <= `RST_TIMER;
      res_r <= 22'h0;
    end else if (tmr_rst) begin
      timer_r <= start_r;
      res_r <= 22'h0;
    end else if (timing && ms_tick) begin
      res_r <= (res_r >= res_ms(range_r) - 22'h1) ? 22'h0 : res_r + 22'h1;
      if (res_r >= res_ms(range_r) - 22'h1) timer_r <= bcd_step(timer_r, dir_r, range_r);
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      disp_r <= `RST_TIMER;
      RUN_DP <= 1'b0;
    end else begin
      // hold mode shows the value captured just before the edge
      if (mode_r != etimer_pkg::display_hold_mode || a_rise || b_rise) disp_r <= timer_r;
      RUN_DP <= run_ind_r & timing & alt_r;
    end
  end
  assign TIMER_VALUE = disp_r;
  assign RUNNING = run_r;
  assign MENU_STATE = state_r;
  assign MENU_SLOT = mod_r;
  assign MENU_ITEM = item_r;
  assign SHOW_VALUE = alt_r;
  assign EDIT_VALUE = edit_r;
  assign FLASH_POS = pos_r;
  assign LOCK_CODE = lock_code_r;
  assign LOCK_HW = lock_hw_r;
  assign NV_WRITE = nv_wr_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  property p_lock_refuse;
    state_r == etimer_pkg::MENU_DISPLAY && par_p && locked |=> state_r == etimer_pkg::MENU_DISPLAY;
  endproperty
  a_lock_refuse: assert property (p_lock_refuse) else $error("locked entry accepted");
  property p_lock_cause;
    state_r == etimer_pkg::MENU_DISPLAY && par_p && s2_r[5] |=> LOCK_HW [*2];
  endproperty
  a_lock_cause: assert property (p_lock_cause) else $error("hardware lock not flagged");
  property p_slot_step;
    state_r == etimer_pkg::MENU_PROMPT && sel_p && !par_p && mod_r != `LAST_SLOT
      |=> mod_r == $past(mod_r) + 3'h1;
  endproperty
  a_slot_step: assert property (p_slot_step) else $error("module select did not step");
  property p_module_done;
    store && item_r == `LAST_ITEM |=> state_r == etimer_pkg::MENU_PROMPT && mod_r == 3'h0;
  endproperty
  a_module_done: assert property (p_module_done) else $error("module end not at prompt");
  property p_store_dir;
    store && item_r == 4'd3 && !bus_wr |=> dir_r == $past(edit_r[0]) && item_r == 4'd4;
  endproperty
  a_store_dir: assert property (p_store_dir) else $error("stored value lost");
  property p_digit_left;
    store && next_item == 4'd4 |=> pos_r == 3'h0 ##1 (sel_p && !par_p) |=> pos_r == 3'h1;
  endproperty
  a_digit_left: assert property (p_digit_left) else $error("flash digit misplaced");
  property p_exit_commit;
    state_r == etimer_pkg::MENU_PROMPT && par_p && mod_r == 3'h0
      |=> NV_WRITE && state_r == etimer_pkg::MENU_DISPLAY ##1 !NV_WRITE;
  endproperty
  a_exit_commit: assert property (p_exit_commit) else $error("exit did not commit");
  property p_inhibit;
    single && b && !tmr_rst |=> timer_r == $past(timer_r);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("timer moved while inhibited");
  property p_reset_start;
    rvar && start_e |=> timer_r == $past(start_r);
  endproperty
  a_reset_start: assert property (p_reset_start) else $error("start edge did not reset");
  property p_stop_value;
    stop_en_r && timing && timer_r == stop_r |=> stop_lat_r && !timing;
  endproperty
  a_stop_value: assert property (p_stop_value) else $error("no stop at stop value");
  property p_stop_hold;
    stop_lat_r && !tmr_rst && !start_e |=> stop_lat_r;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop latch dropped");
  c_enter: cover property (state_r == etimer_pkg::MENU_DISPLAY ##1 state_r == etimer_pkg::MENU_PROMPT);
  c_commit: cover property (nv_wr_r);
  c_stop: cover property (stop_set && timing);
  c_hold: cover property (mode_r == etimer_pkg::display_hold_mode && b_rise && run_r);
endmodule : etimer

// ---- verif/panel_model.sv ----
// front panel key and timer contact model
`timescale 1ns/100ps
module panel_model (
  input wire logic CLK,
  output logic KEY_PAR,
  output logic KEY_SEL,
  output logic KEY_RST,
  output logic IN_A,
  output logic IN_B,
  output logic HW_LOCK
);
  logic [2:0] keys_r = 3'h0;
  logic [2:0] pins_r = 3'h0;
  assign {KEY_PAR, KEY_SEL, KEY_RST} = keys_r;
  assign {IN_A, IN_B, HW_LOCK} = pins_r;
  // key held past sync and edge detect, released long enough to re-arm
  task press(input logic [2:0] k);
    begin
      @(posedge CLK);
      keys_r <= k;
      repeat (6) @(posedge CLK);
      keys_r <= 3'h0;
      repeat (6) @(posedge CLK);
    end
  endtask : press
  task contact(input logic [2:0] p);
    begin
      @(posedge CLK);
      pins_r <= p;
    end
  endtask : contact
endmodule : panel_model

// ---- verif/programmable_elapsed_timer_tb_top.sv ----
// self-checking bench of the elapsed timer
`timescale 1ns/100ps
module programmable_elapsed_timer_tb_top;
  logic CLK = 1'b0, RST = 1'b1, HSEL = 1'b0, HWRITE = 1'b0, HREADYOUT, HRESP, NV_WRITE;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd;
  logic [1:0] HTRANS = 2'h0, MENU_STATE;
  logic [2:0] HSIZE = 3'h2, MENU_SLOT, FLASH_POS;
  logic [3:0] MENU_ITEM;
  logic [23:0] EDIT_VALUE, TIMER_VALUE;
  logic KEY_PAR, KEY_SEL, KEY_RST, IN_A, IN_B, HW_LOCK, SHOW_VALUE, RUN_DP, RUNNING;
  logic LOCK_CODE, LOCK_HW, SETPOINT = 1'b0, NV_RUN = 1'b0;
  int bad_count = 0, n_checks = 0, nv_seen = 0, wt = 0;
  // address, write data, expected read back
  localparam logic [31:0] ROWS [6][3] = '{
    '{32'h00, 32'h12, 32'h00}, '{32'h00, 32'h11, 32'h11}, '{32'h04, 32'h12999999, 32'h999999},
    '{32'h10, 32'h1234, 32'h0}, '{32'h20, 32'hffffffff, 32'h0}, '{32'h0c, 32'hfff, 32'h3ff}};
  initial begin
    forever #20 CLK = ~CLK;
  end
  etimer #(.TICK_CYCLES(15'd10), .DEBOUNCE_CYCLES(21'd20)) i_dut (.CLK(CLK), .RST(RST),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .KEY_PAR(KEY_PAR), .KEY_SEL(KEY_SEL), .KEY_RST(KEY_RST), .IN_A(IN_A),
    .IN_B(IN_B), .HW_LOCK(HW_LOCK), .SETPOINT(SETPOINT), .NV_RUN(NV_RUN),
    .MENU_STATE(MENU_STATE),
    .MENU_SLOT(MENU_SLOT), .MENU_ITEM(MENU_ITEM), .SHOW_VALUE(SHOW_VALUE),
    .EDIT_VALUE(EDIT_VALUE), .FLASH_POS(FLASH_POS), .TIMER_VALUE(TIMER_VALUE),
    .RUN_DP(RUN_DP), .RUNNING(RUNNING), .LOCK_CODE(LOCK_CODE), .LOCK_HW(LOCK_HW),
    .NV_WRITE(NV_WRITE));
  panel_model i_panel (.CLK(CLK), .KEY_PAR(KEY_PAR), .KEY_SEL(KEY_SEL), .KEY_RST(KEY_RST),
    .IN_A(IN_A), .IN_B(IN_B), .HW_LOCK(HW_LOCK));
  always @(posedge CLK) begin
    if (NV_WRITE === 1'b1) nv_seen <= nv_seen + 1;
  end
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask : complete_run
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
      n_checks++;
      if (got !== exp) begin
        $display("[FAIL] %s expected %h seen %h", what, exp, got);
        bad_count++;
      end
    end
  endtask : chk
  // one single word transfer; waits on hready in both phases under a bound
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int n;
    begin
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HADDR <= a;
      HWRITE <= wr;
      HSIZE <= 3'h2;
      n = 0;
      do begin
        @(posedge CLK);
        n++;
      end while (HREADYOUT !== 1'b1 && n < 50);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= wd;
      do begin
        @(posedge CLK);
        n++;
      end while (HREADYOUT !== 1'b1 && n < 100);
      rd = HRDATA;
      if (n >= 100) begin
        bad_count++;
        complete_run();
      end
    end
  endtask : ahb
  initial begin
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    chk("menu after reset", 32'h0, MENU_STATE);
    chk("timer after reset", 32'h0, TIMER_VALUE);
    chk("hready and okay", 32'h2, {HREADYOUT, HRESP});
    for (int i = 0; i < 6; i++) begin
      ahb(1'b1, ROWS[i][0], ROWS[i][1]);
      ahb(1'b0, ROWS[i][0], 32'h0);
      chk("register row", ROWS[i][2], rd);
    end
    i_panel.press(3'h4);
    chk("code lock", 32'h8, {LOCK_CODE, LOCK_HW, MENU_STATE});
    ahb(1'b1, 32'h0c, 32'h0);
    i_panel.contact(3'h1);
    i_panel.press(3'h4);
    chk("hardware lock", 32'h4, {LOCK_CODE, LOCK_HW, MENU_STATE});
    i_panel.contact(3'h0);
    i_panel.press(3'h4);
    i_panel.press(3'h2);
    chk("prompt slot", 32'h9, {MENU_STATE, MENU_SLOT});
    i_panel.press(3'h4);
    chk("edit range", 32'h20, {MENU_STATE, MENU_ITEM});
    i_panel.press(3'h2);
    chk("range wraps", 32'h0, EDIT_VALUE);
    repeat (4) i_panel.press(3'h4);
    chk("start item", 32'h40, {MENU_ITEM, 1'b0, FLASH_POS});
    i_panel.press(3'h1);
    chk("digit rolls", 32'h999990, EDIT_VALUE);
    i_panel.press(3'h2);
    i_panel.press(3'h1);
    chk("left digit", 32'h1999900, {FLASH_POS, EDIT_VALUE});
    repeat (2) i_panel.press(3'h4);
    chk("stop value skipped", 32'h7, MENU_ITEM);
    ahb(1'b0, 32'h04, 32'h0);
    chk("start stored", 32'h999900, rd);
    ahb(1'b0, 32'h00, 32'h0);
    chk("range stored", 32'h0, rd);
    repeat (3) i_panel.press(3'h4);
    chk("exit prompt", 32'h8, {MENU_STATE, MENU_SLOT});
    i_panel.press(3'h4);
    chk("commit pulse", 32'h1, nv_seen);
    chk("back to display", 32'h0, MENU_STATE);
    ahb(1'b1, 32'h00, 32'h403);
    ahb(1'b1, 32'h08, 32'h20);
    ahb(1'b1, 32'h04, 32'h0);
    ahb(1'b1, 32'h18, 32'h1);
    i_panel.contact(3'h6);
    repeat (10) @(posedge CLK);
    chk("level run", 32'h1, RUNNING);
    repeat (200) @(posedge CLK);
    chk("inhibited", 32'h0, TIMER_VALUE);
    i_panel.contact(3'h4);
    repeat (400) @(posedge CLK);
    chk("stop value", 32'h20, TIMER_VALUE);
    ahb(1'b0, 32'h14, 32'h0);
    chk("stop latched", 32'h1, rd[2]);
    ahb(1'b1, 32'h00, 32'h803);
    ahb(1'b1, 32'h18, 32'h1);
    // point follows the name/value phase, which turns only every half second
    while (RUN_DP !== 1'b1 && wt < 12000) begin
      @(posedge CLK);
      wt++;
    end
    chk("run point", 32'h1, RUN_DP);
    chk("value phase", 32'h1, SHOW_VALUE);
    ahb(1'b1, 32'h00, 32'h4003);
    ahb(1'b0, 32'h14, 32'h0);
    chk("latch cleared", 32'h0, rd[2]);
    SETPOINT <= 1'b1;
    repeat (3) @(posedge CLK);
    ahb(1'b0, 32'h14, 32'h0);
    chk("setpoint stop", 32'h1, rd[2]);
    NV_RUN <= 1'b1;
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    chk("stopped at release", 32'h0, RUNNING);
    chk("timer at release", 32'h0, TIMER_VALUE);
    repeat (3) @(posedge CLK);
    chk("level ignores restore", 32'h1, RUNNING);
    complete_run();
  end
endmodule : programmable_elapsed_timer_tb_top
